// [pkg/hfwc_consts.vh]
/*
 * Constants of the hop frequency word composer: register offsets,
 * field positions, reset values and pulse timing.
 * Assumes a 20 MHz clock and a 32-bit AHB-Lite register bus.
 */
`ifndef HFWC_CONSTS_VH
`define HFWC_CONSTS_VH

// clock and pulse interval timing
`define HFWC_CLK_HZ 20000000
`define HFWC_PULSE_US 200
`define HFWC_PULSE_CYC ((`HFWC_CLK_HZ / 1000000) * `HFWC_PULSE_US)
`define HFWC_SYNC_EVERY 25
// sized forms of the interval and sync counts, for 12-bit and 5-bit counters
`define HFWC_PULSE_LEN 12'hFA0
`define HFWC_PULSE_LAST 12'hF9F
`define HFWC_SYNC_LAST 5'h18

// word widths
`define HFWC_HOP_W 12
`define HFWC_SYM_W 4
`define HFWC_DOP_W 9
`define HFWC_CMD_W 15

// bit placement inside the 15-bit command sum
`define HFWC_HOP_LSB 3
`define HFWC_SYM_LSB 4
`define HFWC_DOP_LSB 0

// hop word ceiling, up to which the transmit three-way sum stays below 2^15
`define HFWC_HOP_MAX 12'hFA1
`define HFWC_HOP_FOLD 12'h800

// register byte offsets
`define HFWC_REG_CTRL 8'h00
`define HFWC_REG_TX_SEED 8'h04
`define HFWC_REG_RX_SEED 8'h08
`define HFWC_REG_UL_DOP 8'h0C
`define HFWC_REG_DL_DOP 8'h10
`define HFWC_REG_TX_DELAY 8'h14
`define HFWC_REG_RX_DELAY 8'h18
`define HFWC_REG_STATUS 8'h1C
`define HFWC_REG_CMD 8'h20

// control bits
`define HFWC_CTRL_EN 0
`define HFWC_CTRL_RELOAD 1

// reset values
`define HFWC_SEED_RST 12'h001
`define HFWC_CTRL_RST 2'h0

`endif

// [rtl/hfwc_seq_gen.v]
/*
 * Pseudorandom hop word generator, 12-bit maximal LFSR, one step per
 * pulse interval. Used identically for transmitter and receiver.
 * Assumes step and load are one-cycle strobes on the same clock.
 */
`timescale 1ns/1ps
`include "hfwc_consts.vh"

module hfwc_seq_gen (
   input wire clock,
   input wire srst,
   input wire load,
   input wire [11:0] seed,
   input wire step,
   output wire [11:0] hop_next
);

   reg [11:0] lfsr_q;
   reg [11:0] lfsr_d;
   reg [11:0] raw;

   // next state; the hop output is folded so the transmit command sum can never reach 2^15
   always @* begin
      lfsr_d = {lfsr_q[10:0], lfsr_q[11] ^ lfsr_q[5] ^ lfsr_q[3] ^ lfsr_q[0]};
      raw = lfsr_d;
      if (raw > `HFWC_HOP_MAX) begin
         raw = raw - `HFWC_HOP_FOLD;
      end
   end

   assign hop_next = raw;

   // zero state would lock the register, so a zero seed becomes one
   always @(posedge clock) begin
      if (srst) begin
         lfsr_q <= `HFWC_SEED_RST;
      end else if (load) begin
         lfsr_q <= (seed == 12'h000) ? `HFWC_SEED_RST : seed;
      end else if (step) begin
         lfsr_q <= lfsr_d;
      end
   end

endmodule

// [rtl/hfwc_time_base.v]
/*
 * Hop time base: fires a one-cycle strobe once per pulse interval at a
 * chosen phase of the shared reference interval counter.
 * Assumes phase is already reduced below the interval length.
 */
`timescale 1ns/1ps
`include "hfwc_consts.vh"

module hfwc_time_base (
   input wire clock,
   input wire srst,
   input wire enable,
   input wire [11:0] ref_cnt,
   input wire [11:0] phase,
   output reg strobe
);

   // one strobe per interval, shifted by the programmed delay
   always @(posedge clock) begin
      if (srst) begin
         strobe <= 1'b0;
      end else begin
         strobe <= enable && (ref_cnt == phase);
      end
   end

endmodule

// [rtl/hfwc_top.v]
/*
 * Hop frequency word composer: builds the 15-bit synthesizer commands
 * for the transmitter and the receiver local oscillator once per pulse
 * interval, with an AHB-Lite slave for the orbit computer's settings.
 * Assumes encoder symbol and AFC error arrive on this clock.
 */
// Contract
// - new 12-bit hop word each interval
// - symbol steps base by 10 kHz units
// - 9-bit up-link Doppler added, 625 Hz resolution
// - three words summed into one 15-bit command
// - bit0 625 Hz, symbol at bits 7..4
// - hop at bits 14..3, Doppler 8..0
// - new pseudorandom command every interval
// - receiver command restepped every interval too
// - receiver sums hop, down-link Doppler, AFC
// - identical receiver generator on aligned time base
// - every 25th pulse symbol forced zero
// - transmit time advanced by up-link delay
// - receiver corrected by down-link delay, Doppler
// - one 4-bit symbol taken per interval
`timescale 1ns/1ps
`include "hfwc_consts.vh"

module hfwc_top (
   input wire clock,
   input wire srst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [3:0] enc_symbol,
   input wire [8:0] afc_error,
   output reg [14:0] tx_freq_cmd,
   output reg [14:0] rx_freq_cmd,
   output reg tx_pulse_start,
   output reg rx_pulse_start,
   output reg tx_sync_pulse
);

   // software-visible state
   reg [1:0] ctrl_q;
   reg reload_q;
   reg [11:0] tx_seed_q;
   reg [11:0] rx_seed_q;
   reg [8:0] ul_dop_q;
   reg [8:0] dl_dop_q;
   reg [11:0] tx_delay_q;
   reg [11:0] rx_delay_q;

   // bus data phase bookkeeping
   reg wr_pend_q;
   reg [7:0] wr_addr_q;
   reg [31:0] rd_d;

   // timing state
   reg [11:0] ref_cnt_q;
   reg [4:0] sync_cnt_q;
   wire tx_strobe;
   wire rx_strobe;
   wire [11:0] tx_hop_next;
   wire [11:0] rx_hop_next;
   wire [11:0] tx_phase;
   wire [11:0] rx_phase;
   wire enable;
   wire bus_take;

   localparam [11:0] PULSE_LAST = `HFWC_PULSE_LAST;
   localparam [11:0] PULSE_LEN = `HFWC_PULSE_LEN;
   localparam [4:0] SYNC_LAST = `HFWC_SYNC_LAST;

   // delays at or beyond one interval fold back into it
   function [11:0] wrap_phase;
      input [11:0] d;
      begin
         if (d >= PULSE_LEN) begin
            wrap_phase = d - PULSE_LEN;
         end else begin
            wrap_phase = d;
         end
      end
   endfunction

   // transmit command: hop at 14..3, symbol at 7..4, Doppler at 8..0
   function [14:0] tx_compose;
      input [11:0] hop;
      input [3:0] sym;
      input [8:0] dop;
      begin
         tx_compose = {hop, 3'h0}
            + {7'h00, sym, 4'h0}
            + {6'h00, dop};
      end
   endfunction

   // receiver command: AFC error is two's complement, sum wraps
   function [14:0] rx_compose;
      input [11:0] hop;
      input [8:0] dop;
      input [8:0] afc;
      begin
         rx_compose = {hop, 3'h0} + {6'h00, dop}
            + {{6{afc[8]}}, afc};
      end
   endfunction

   assign enable = ctrl_q[`HFWC_CTRL_EN];
   assign bus_take = hsel && hready && htrans[1];

   // transmit fires early by the up-link delay, receiver late by down-link
   assign tx_phase = (wrap_phase(tx_delay_q) == 12'h000) ? 12'h000
      : PULSE_LEN - wrap_phase(tx_delay_q);
   assign rx_phase = wrap_phase(rx_delay_q);

   // reference interval counter, one 200 us interval per wrap
   always @(posedge clock) begin
      if (srst) begin
         ref_cnt_q <= 12'h000;
      end else if (ref_cnt_q == PULSE_LAST) begin
         ref_cnt_q <= 12'h000;
      end else begin
         ref_cnt_q <= ref_cnt_q + 12'h001;
      end
   end

   hfwc_time_base u_tx_tb (
      .clock(clock),
      .srst(srst),
      .enable(enable),
      .ref_cnt(ref_cnt_q),
      .phase(tx_phase),
      .strobe(tx_strobe)
   );

   // receiver time base shares the reference counter
   hfwc_time_base u_rx_tb (
      .clock(clock),
      .srst(srst),
      .enable(enable),
      .ref_cnt(ref_cnt_q),
      .phase(rx_phase),
      .strobe(rx_strobe)
   );

   hfwc_seq_gen u_tx_seq (
      .clock(clock),
      .srst(srst),
      .load(reload_q),
      .seed(tx_seed_q),
      .step(tx_strobe),
      .hop_next(tx_hop_next)
   );

   // same generator as the transmitter, so both hop alike
   hfwc_seq_gen u_rx_seq (
      .clock(clock),
      .srst(srst),
      .load(reload_q),
      .seed(rx_seed_q),
      .step(rx_strobe),
      .hop_next(rx_hop_next)
   );

   // sync pulse position counter, one slot per transmit interval
   always @(posedge clock) begin
      if (srst || reload_q) begin
         sync_cnt_q <= 5'h00;
      end else if (tx_strobe) begin
         if (sync_cnt_q == SYNC_LAST) begin
            sync_cnt_q <= 5'h00;
         end else begin
            sync_cnt_q <= sync_cnt_q + 5'h01;
         end
      end
   end

   // transmit command: taken at interval start, held until the next
   always @(posedge clock) begin
      if (srst) begin
         tx_freq_cmd <= 15'h0000;
         tx_sync_pulse <= 1'b0;
         tx_pulse_start <= 1'b0;
      end else begin
         tx_pulse_start <= tx_strobe;
         if (tx_strobe) begin
            // symbol sampled once per interval; sync slot carries no data
            if (sync_cnt_q == SYNC_LAST) begin
               tx_freq_cmd <= tx_compose(tx_hop_next, 4'h0, ul_dop_q);
               tx_sync_pulse <= 1'b1;
            end else begin
               tx_freq_cmd <= tx_compose(tx_hop_next, enc_symbol, ul_dop_q);
               tx_sync_pulse <= 1'b0;
            end
         end
      end
   end

   // receiver command restepped each receiver interval
   always @(posedge clock) begin
      if (srst) begin
         rx_freq_cmd <= 15'h0000;
         rx_pulse_start <= 1'b0;
      end else begin
         rx_pulse_start <= rx_strobe;
         if (rx_strobe) begin
            rx_freq_cmd <= rx_compose(rx_hop_next, dl_dop_q, afc_error);
         end
      end
   end

   // read mux, evaluated in the address phase
   always @* begin
      rd_d = 32'h00000000;
      case (haddr[7:0])
         `HFWC_REG_CTRL: rd_d = {31'h00000000, ctrl_q[`HFWC_CTRL_EN]};
         `HFWC_REG_TX_SEED: rd_d = {20'h00000, tx_seed_q};
         `HFWC_REG_RX_SEED: rd_d = {20'h00000, rx_seed_q};
         `HFWC_REG_UL_DOP: rd_d = {23'h000000, ul_dop_q};
         `HFWC_REG_DL_DOP: rd_d = {23'h000000, dl_dop_q};
         `HFWC_REG_TX_DELAY: rd_d = {20'h00000, tx_delay_q};
         `HFWC_REG_RX_DELAY: rd_d = {20'h00000, rx_delay_q};
         `HFWC_REG_STATUS: rd_d = {11'h000, tx_sync_pulse, sync_cnt_q, 3'h0, ref_cnt_q};
         `HFWC_REG_CMD: rd_d = {1'b0, rx_freq_cmd, 1'b0, tx_freq_cmd};
         default: rd_d = 32'h00000000;
      endcase
   end

   // zero wait states: read data registered at the address phase edge
   always @(posedge clock) begin
      if (srst) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= bus_take && hwrite;
         if (bus_take) begin
            wr_addr_q <= haddr[7:0];
         end
         if (bus_take && !hwrite) begin
            hrdata <= rd_d;
         end
      end
   end

   // register writes land in the data phase; unmapped ones are dropped
   always @(posedge clock) begin
      if (srst) begin
         ctrl_q <= `HFWC_CTRL_RST;
         reload_q <= 1'b0;
         tx_seed_q <= `HFWC_SEED_RST;
         rx_seed_q <= `HFWC_SEED_RST;
         ul_dop_q <= 9'h000;
         dl_dop_q <= 9'h000;
         tx_delay_q <= 12'h000;
         rx_delay_q <= 12'h000;
      end else begin
         reload_q <= 1'b0;
         if (wr_pend_q) begin
            case (wr_addr_q)
               `HFWC_REG_CTRL: begin
                  ctrl_q[`HFWC_CTRL_EN] <= hwdata[`HFWC_CTRL_EN];
                  reload_q <= hwdata[`HFWC_CTRL_RELOAD];
               end
               `HFWC_REG_TX_SEED: tx_seed_q <= hwdata[11:0];
               `HFWC_REG_RX_SEED: rx_seed_q <= hwdata[11:0];
               `HFWC_REG_UL_DOP: ul_dop_q <= hwdata[8:0];
               `HFWC_REG_DL_DOP: dl_dop_q <= hwdata[8:0];
               `HFWC_REG_TX_DELAY: tx_delay_q <= hwdata[11:0];
               `HFWC_REG_RX_DELAY: rx_delay_q <= hwdata[11:0];
               default: ctrl_q <= ctrl_q;
            endcase
         end
      end
   end

endmodule

// [dv/hfwc_properties.sv]
/* checker: timing of the synthesizer command ports of hfwc_top.
   assumes delays and enable stay unchanged while the paths run. */
`timescale 1ns/1ps
module hfwc_properties (
   input wire clock,
   input wire srst,
   input wire [14:0] tx_freq_cmd,
   input wire [14:0] rx_freq_cmd,
   input wire tx_pulse_start,
   input wire rx_pulse_start,
   input wire tx_sync_pulse
);
   reg [12:0] tx_gap_q, rx_gap_q, sync_len_q;
   reg tx_seen_q, rx_seen_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // cycle counts since each pulse, sync length in cycles
   always @(posedge clock) begin
      if (srst) begin
         tx_gap_q <= 13'h0;
         rx_gap_q <= 13'h0;
         sync_len_q <= 13'h0;
         tx_seen_q <= 1'b0;
         rx_seen_q <= 1'b0;
      end else begin
         tx_gap_q <= tx_pulse_start ? 13'h0 : tx_gap_q + 13'h1;
         rx_gap_q <= rx_pulse_start ? 13'h0 : rx_gap_q + 13'h1;
         sync_len_q <= tx_sync_pulse ? sync_len_q + 13'h1 : 13'h0;
         tx_seen_q <= tx_seen_q | tx_pulse_start;
         rx_seen_q <= rx_seen_q | rx_pulse_start;
      end
   end
   a_tx_cmd_hold:
      assert property (!tx_pulse_start |-> $stable(tx_freq_cmd)) else $error("tx cmd moved");
   a_rx_cmd_hold:
      assert property (!rx_pulse_start |-> $stable(rx_freq_cmd)) else $error("rx cmd moved");
   a_tx_pulse_lone:
      assert property (tx_pulse_start |=> !tx_pulse_start [*8]) else $error("tx pulse long");
   a_tx_period:
      assert property (tx_pulse_start && tx_seen_q |-> tx_gap_q == 13'h0F9F)
         else $error("tx interval length");
   a_rx_period:
      assert property (rx_pulse_start && rx_seen_q |-> rx_gap_q == 13'h0F9F)
         else $error("rx interval length");
   a_sync_at_start:
      assert property (!tx_pulse_start |-> $stable(tx_sync_pulse)) else $error("sync moved");
   a_sync_one_slot:
      assert property ($fell(tx_sync_pulse) |-> sync_len_q == 13'h0FA0)
         else $error("sync length");
   a_rx_pulse_lone:
      assert property (rx_pulse_start |=> !rx_pulse_start [*8]) else $error("rx pulse long");
   cover property (tx_pulse_start && tx_seen_q);
   cover property (rx_pulse_start && rx_seen_q);
   cover property ($fell(tx_sync_pulse));
endmodule
bind hfwc_top hfwc_properties chk_u (.clock(clock), .srst(srst), .tx_freq_cmd(tx_freq_cmd),
   .rx_freq_cmd(rx_freq_cmd), .tx_pulse_start(tx_pulse_start),
   .rx_pulse_start(rx_pulse_start), .tx_sync_pulse(tx_sync_pulse));

// [dv/hfwc_synth_model.sv]
/* synthesizer model: takes a 15-bit command at its pulse start.
   assumes the composer's clock; reports tuned offset in hertz. */
`timescale 1ns/1ps
module hfwc_synth_model (
   input wire clock,
   input wire srst,
   input wire [14:0] cmd,
   input wire pulse_start,
   output reg [24:0] tuned_hz,
   output reg fault
);
   reg [14:0] held_q;
   // retune on pulses only; a silent change would detune mid pulse
   always @(posedge clock) begin
      if (srst) begin
         held_q <= 15'h0;
         tuned_hz <= 25'h0;
         fault <= 1'b0;
      end else begin
         if (pulse_start)
            held_q <= cmd;
         else if (cmd !== held_q)
            fault <= 1'b1;
         tuned_hz <= {10'h0, held_q} * 25'h271;
      end
   end
endmodule

// [dv/tb.sv]
/* testbench of hfwc_top: register access, then 26 hop intervals.
   assumes the synth models stand on both command outputs. */
`timescale 1ns/1ps
`include "hfwc_consts.vh"
module tb;
   reg clock, srst, hsel, hwrite;
   reg [31:0] haddr, hwdata, rd;
   reg [1:0] htrans;
   reg [2:0] hsize;
   reg [3:0] enc_symbol;
   reg [8:0] afc_error;
   wire [31:0] hrdata;
   wire hreadyout, hresp, tx_pulse_start, rx_pulse_start, tx_sync_pulse, tx_fault, rx_fault;
   wire [14:0] tx_freq_cmd, rx_freq_cmd;
   wire [24:0] tx_hz;
   integer fail_count = 0, checked = 0, cyc = 0;
   hfwc_top dut_u (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .enc_symbol(enc_symbol), .afc_error(afc_error),
      .tx_freq_cmd(tx_freq_cmd), .rx_freq_cmd(rx_freq_cmd), .tx_pulse_start(tx_pulse_start),
      .rx_pulse_start(rx_pulse_start), .tx_sync_pulse(tx_sync_pulse));
   hfwc_synth_model tx_syn_u (.clock(clock), .srst(srst), .cmd(tx_freq_cmd),
      .pulse_start(tx_pulse_start), .tuned_hz(tx_hz), .fault(tx_fault));
   hfwc_synth_model rx_syn_u (.clock(clock), .srst(srst), .cmd(rx_freq_cmd),
      .pulse_start(rx_pulse_start), .tuned_hz(), .fault(rx_fault));
   // 50 ns clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task report_and_stop;
      begin
         $display("checked %0d mismatches %0d", checked, fail_count);
         if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input reg ok, input string m);
      begin
         checked = checked + 1;
         if (ok !== 1'b1) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: %s", $time, m);
         end
      end
   endtask
   // one single word transfer; waits on hready in both phases
   task bus(input reg w, input reg [7:0] a, input reg [31:0] wd);
      begin
         @(posedge clock);
         hsel <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         haddr <= {24'h0, a};
         do @(posedge clock); while (hreadyout !== 1'b1);
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= wd;
         do @(posedge clock); while (hreadyout !== 1'b1);
         rd = hrdata;
         chk(hresp === 1'b0, "response");
      end
   endtask
   function reg [11:0] step(input reg [11:0] q);
      step = {q[10:0], q[11] ^ q[5] ^ q[3] ^ q[0]};
   endfunction
   function reg [11:0] fold(input reg [11:0] n);
      fold = (n > 12'hFA1) ? n - 12'h800 : n;
   endfunction
   task regs_scenario;
      begin
         bus(0, `HFWC_REG_CTRL, 32'h0);
         chk(rd === 32'h0, "ctrl reset");
         bus(0, `HFWC_REG_TX_SEED, 32'h0);
         chk(rd === 32'h1, "seed reset");
         bus(1, 8'h40, 32'hFFFFFFFF);
         bus(0, 8'h40, 32'h0);
         chk(rd === 32'h0, "unmapped");
         bus(1, `HFWC_REG_UL_DOP, 32'hFFFFFFFF);
         bus(0, `HFWC_REG_UL_DOP, 32'h0);
         chk(rd === 32'h1FF, "doppler width");
         bus(1, `HFWC_REG_DL_DOP, 32'hAB);
         bus(1, `HFWC_REG_TX_SEED, 32'h5A3);
         bus(1, `HFWC_REG_RX_SEED, 32'h3C7);
         // tx phase 100: first sync interval arrives early, keeps the run short
         bus(1, `HFWC_REG_TX_DELAY, 32'hF3C);
         bus(1, `HFWC_REG_RX_DELAY, 32'h3E8);
         bus(0, `HFWC_REG_RX_SEED, 32'h0);
         chk(rd === 32'h3C7, "seed readback");
      end
   endtask
   // both paths hop; symbols walk all codes, sync found by spacing
   task hop_scenario;
      reg [11:0] tq, rq;
      reg [14:0] te, re;
      reg [3:0] sym;
      reg [8:0] afc;
      integer n, ns, first, last, gap;
      begin
         tq = 12'h5A3;
         rq = 12'h3C7;
         sym = 4'h0;
         afc = 9'h100;
         n = 0;
         ns = 0;
         first = 0;
         last = 0;
         gap = -1;
         bus(1, `HFWC_REG_CTRL, 32'h3);
         while (n < 26) begin
            @(posedge clock);
            if (gap >= 0)
               gap = gap + 1;
            if (tx_pulse_start === 1'b1) begin
               tq = step(tq);
               te = {fold(tq), 3'h0} + {7'h0, (n == 24) ? 4'h0 : sym, 4'h0} + 15'h1FF;
               chk(tx_freq_cmd === te, "tx command");
               chk(tx_sync_pulse === (n == 24), "sync flag");
               chk(fold(tq) <= 12'hFA1, "hop range");
               // rx at ref 1000, tx at ref 4000 - 3900 in the next interval
               chk(gap == 3100 || gap < 0, "tx start offset");
               if (tx_sync_pulse === 1'b1) begin
                  ns = ns + 1;
                  first = (ns == 1) ? n : first;
                  last = n;
               end
               n = n + 1;
               sym = sym + 4'h3;
               enc_symbol <= sym;
            end
            if (rx_pulse_start === 1'b1) begin
               rq = step(rq);
               re = {fold(rq), 3'h0} + 15'h0AB + {{6{afc[8]}}, afc};
               chk(rx_freq_cmd === re, "rx command");
               gap = 0;
               afc = afc - 9'h25;
               afc_error <= afc;
            end
         end
         chk(ns == 1 && first == 24 && last == 24, "sync spacing");
         repeat (2) @(posedge clock);
         chk(tx_hz === {10'h0, tx_freq_cmd} * 25'h271, "tuned hz");
         chk(tx_fault === 1'b0 && rx_fault === 1'b0, "synth retune");
         bus(0, `HFWC_REG_CMD, 32'h0);
         chk(rd === {1'b0, re, 1'b0, te}, "command readback");
         // slot 24 wrapped to 0 and the 26th interval moved it to 1
         bus(0, `HFWC_REG_STATUS, 32'h0);
         chk(rd[20:15] === 6'h01, "sync slot");
         bus(0, `HFWC_REG_CTRL, 32'h0);
         chk(rd === 32'h1, "reload reads zero");
      end
   endtask
   // hang guard: 25 intervals plus 1000 cycles of margin
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 101000) begin
         fail_count = fail_count + 1;
         report_and_stop;
      end
   end
   initial begin
      srst = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      enc_symbol = 4'h0;
      afc_error = 9'h100;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      regs_scenario;
      hop_scenario;
      report_and_stop;
   end
endmodule
